/* rtl/hsw_pkg.sv */
// Behaviour
// - Writing the suspend code into the state field (cmd 01H/81H) enters suspend.
// - While stopped, switch off clock, PLL and crystal; put the regulator in power-down.
// - Suspend indicator pin goes high when the state field enters suspend.
// - Indicator returns low only when the field is written to reset or operational.
// - With hardware_setup bit 11 low, stop the clock after 1.3 ms of suspend.
// - Wake pin high in suspend restarts the clock and sets clock-up flag bit 6.
// - Internal clock is running 160 us after the wake pin rises.
// - While the wake pin stays high the clock keeps running; the code holds the clock on only after a hardware wake.
// - Wake pin low over 1.14 ms after a hardware wake stops the clock again.
// - A chip-select access during suspend wakes the clock as software wake.
// - Bus resume moves suspend to resume and sets the resume-seen flag.
// - Read command code is the standard register offset divided by four.
// - Remote wake enable and resume-seen together signal remote wake-up.
package hsw_pkg;

    // Clock and documented times
    localparam int CLK_PERIOD_NS = 5;
    localparam int SUSP_STOP_NS = 1300000;
    localparam int WAKE_UP_NS = 160000;
    localparam int WAKE_LOW_NS = 1140000;
    localparam int TIMER_W = 20;

    // Register indexes, command bit 7 marks a write
    localparam logic [6:0] IDX_MODE_CTL = 7'h01;
    localparam logic [6:0] IDX_HOST_FLAGS = 7'h03;
    localparam logic [6:0] IDX_HOST_EN = 7'h04;
    localparam logic [6:0] IDX_HW_SETUP = 7'h20;
    localparam logic [6:0] IDX_PROC_FLAGS = 7'h24;
    localparam logic [6:0] IDX_PROC_EN = 7'h25;
    localparam logic [6:0] IDX_FIRST_16 = 7'h20;
    localparam int CMD_WRITE_BIT = 7;

    // Field positions
    localparam int FS_LSB = 6;
    localparam int WAKE_EN_BIT = 10;
    localparam int KEEP_CLK_BIT = 11;
    localparam int CLK_UP_BIT = 6;
    localparam int RESUME_SEEN_BIT = 6;

    // Values after reset
    localparam logic [31:0] MODE_CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] HOST_EN_RESET = 32'h0000_0000;
    localparam logic [15:0] HW_SETUP_RESET = 16'h0000;
    localparam logic [15:0] PROC_EN_RESET = 16'h0000;

    typedef enum logic [1:0] {
        FS_RESET = 2'b00,
        FS_RESUME = 2'b01,
        FS_OPER = 2'b10,
        FS_SUSP = 2'b11
    } hsw_fs_t;

    typedef enum logic [2:0] {
        PW_RUN = 3'b000,
        PW_SUSP_WAIT = 3'b001,
        PW_STOPPED = 3'b010,
        PW_WAKING = 3'b011,
        PW_AWAKE = 3'b100
    } hsw_pw_t;

    // Parallel host bus pins as seen by the block
    typedef struct packed {
        logic csN;
        logic rdN;
        logic wrN;
        logic a0;
        logic [15:0] data;
    } hsw_bus_in_t;

    localparam int SYNC_W = $bits(hsw_bus_in_t) + 2;
    localparam logic [SYNC_W-1:0] SYNC_RESET = {3'b111, 1'b0, 16'h0000, 2'b00};

endpackage

/* rtl/hsw_sync.sv */
`timescale 1ns/10ps
module hsw_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : g_chk
        $error("hsw_sync needs WIDTH of at least 1");
    end

    // Two flops; only the second stage is visible outside
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stage1 <= RESET_VAL;
            synced <= RESET_VAL;
        end else begin
            stage1 <= async;
            synced <= stage1;
        end
    end
endmodule

/* rtl/hsw_wake_ctrl.sv */
`timescale 1ns/10ps
module hsw_wake_ctrl #(
    parameter int SUSP_STOP_CYC =
        (hsw_pkg::SUSP_STOP_NS + hsw_pkg::CLK_PERIOD_NS - 1) / hsw_pkg::CLK_PERIOD_NS,
    parameter int WAKE_UP_CYC = hsw_pkg::WAKE_UP_NS / hsw_pkg::CLK_PERIOD_NS,
    parameter int WAKE_LOW_CYC =
        (hsw_pkg::WAKE_LOW_NS + hsw_pkg::CLK_PERIOD_NS - 1) / hsw_pkg::CLK_PERIOD_NS
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire hsw_pkg::hsw_bus_in_t busIn,
    input wire logic wakeRequestPin,
    input wire logic resumeSignal,
    output logic [15:0] busDataOut,
    output logic busDataOeN,
    output logic suspendPin,
    output logic clockOn,
    output logic pllOn,
    output logic xtalOn,
    output logic regulatorDown,
    output logic remoteWake
);
    import hsw_pkg::*;

    localparam int TMAX = (1 << TIMER_W) - 1;

    if (SUSP_STOP_CYC < 1 || WAKE_UP_CYC < 1 || WAKE_LOW_CYC < 1 ||
        SUSP_STOP_CYC > TMAX || WAKE_UP_CYC > TMAX || WAKE_LOW_CYC >= TMAX) begin : g_chk
        $error("hsw_wake_ctrl cycle counts out of timer range");
    end

    logic [SYNC_W-1:0] syncOut;
    hsw_bus_in_t bus;
    logic wakeS, resumeS, prevRdN, prevWrN, wordHi, clockUp, resumeSeen, hwWake;
    logic [7:0] cmd;
    logic [15:0] lowHold, hwSetup, procEn;
    logic [31:0] modeCtl, hostEn, readVal;
    logic [TIMER_W-1:0] timer;
    hsw_pw_t state, next_state;

    // Every pin passes two flops before use
    hsw_sync #(.WIDTH(SYNC_W), .RESET_VAL(SYNC_RESET)) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async({busIn, wakeRequestPin, resumeSignal}),
        .synced(syncOut)
    );

    assign bus = syncOut[SYNC_W-1:2];
    assign wakeS = syncOut[1];
    assign resumeS = syncOut[0];

    // Strobe edges and decoded accesses
    logic rdStrobe, wrStrobe, wrCmd, wrData, rdData, is32, commit, csActive, suspended;
    logic [31:0] wrVal;
    logic [1:0] wrFs;
    assign rdStrobe = prevRdN & ~bus.rdN & ~bus.csN;
    assign wrStrobe = prevWrN & ~bus.wrN & ~bus.csN;
    assign wrCmd = wrStrobe & bus.a0;
    assign wrData = wrStrobe & ~bus.a0 & cmd[CMD_WRITE_BIT];
    assign rdData = rdStrobe & ~bus.a0;
    assign is32 = cmd[6:0] < IDX_FIRST_16;
    assign commit = wrData & (~is32 | wordHi);
    assign wrVal = is32 ? {bus.data, lowHold} : {16'h0000, bus.data};
    assign wrFs = wrVal[FS_LSB+1:FS_LSB];
    assign csActive = ~bus.csN;
    assign suspended = modeCtl[FS_LSB+1:FS_LSB] == FS_SUSP;

    function automatic logic regWr(input logic c, input logic [7:0] k, input logic [6:0] idx);
        regWr = c & (k[6:0] == idx);
    endfunction

    // Command byte, word pointer and low-half holding for 32-bit registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prevRdN <= 1'b1;
            prevWrN <= 1'b1;
            cmd <= 8'h00;
            wordHi <= 1'b0;
            lowHold <= 16'h0000;
        end else begin
            prevRdN <= bus.rdN;
            prevWrN <= bus.wrN;
            if (wrCmd) begin
                cmd <= bus.data[7:0];
                wordHi <= 1'b0;
            end else if ((wrData | rdData) & is32) begin
                wordHi <= ~wordHi;
            end
            if (wrData & is32 & ~wordHi) begin
                lowHold <= bus.data;
            end
        end
    end

    // Read mux; unmapped codes and unused bits read zero
    always_comb begin
        readVal = '0;
        case (cmd[6:0])
            IDX_MODE_CTL: readVal = modeCtl;
            IDX_HOST_FLAGS: readVal[RESUME_SEEN_BIT] = resumeSeen;
            IDX_HOST_EN: readVal = hostEn;
            IDX_HW_SETUP: readVal[15:0] = hwSetup;
            IDX_PROC_FLAGS: readVal[CLK_UP_BIT] = clockUp;
            IDX_PROC_EN: readVal[15:0] = procEn;
            default: readVal = '0;
        endcase
    end

    // Read data latched on the read strobe, held while the host reads
    always_ff @(posedge core_clk) begin
        if (reset) begin
            busDataOut <= 16'h0000;
            busDataOeN <= 1'b1;
        end else begin
            busDataOeN <= bus.csN | bus.rdN;
            if (rdData) begin
                busDataOut <= (is32 & wordHi) ? readVal[31:16] : readVal[15:0];
            end
        end
    end

    // Plain read/write registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hostEn <= HOST_EN_RESET;
            hwSetup <= HW_SETUP_RESET;
            procEn <= PROC_EN_RESET;
        end else begin
            if (regWr(commit, cmd, IDX_HOST_EN)) hostEn <= wrVal;
            if (regWr(commit, cmd, IDX_HW_SETUP)) hwSetup <= wrVal[15:0];
            if (regWr(commit, cmd, IDX_PROC_EN)) procEn <= wrVal[15:0];
        end
    end

    // Mode control; bus resume forces the state field to resume
    always_ff @(posedge core_clk) begin
        if (reset) begin
            modeCtl <= MODE_CTL_RESET;
        end else if (regWr(commit, cmd, IDX_MODE_CTL)) begin
            modeCtl <= wrVal;
        end else if (resumeS & suspended) begin
            modeCtl[FS_LSB+1:FS_LSB] <= FS_RESUME;
        end
    end

    // Indicator: set by a suspend write, cleared only by reset or operational
    always_ff @(posedge core_clk) begin
        if (reset) begin
            suspendPin <= 1'b0;
        end else if (regWr(commit, cmd, IDX_MODE_CTL)) begin
            if (wrFs == FS_SUSP) begin
                suspendPin <= 1'b1;
            end else if (wrFs == FS_RESET || wrFs == FS_OPER) begin
                suspendPin <= 1'b0;
            end
        end
    end

    // Event flags: write one to clear, a new event wins over the clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            clockUp <= 1'b0;
            resumeSeen <= 1'b0;
            remoteWake <= 1'b0;
        end else begin
            clockUp <= (state == PW_WAKING && hwWake && timer == TIMER_W'(WAKE_UP_CYC - 1)) |
                (clockUp & ~(regWr(commit, cmd, IDX_PROC_FLAGS) & wrVal[CLK_UP_BIT]));
            resumeSeen <= (resumeS & suspended) |
                (resumeSeen & ~(regWr(commit, cmd, IDX_HOST_FLAGS) & wrVal[RESUME_SEEN_BIT]));
            remoteWake <= modeCtl[WAKE_EN_BIT] & resumeSeen;
        end
    end

    // Power state sequencing
    always_comb begin
        next_state = state;
        case (state)
            PW_RUN: begin
                if (suspended) next_state = PW_SUSP_WAIT;
            end
            PW_SUSP_WAIT: begin
                if (!suspended) begin
                    next_state = PW_RUN;
                end else if (!hwSetup[KEEP_CLK_BIT] && !csActive &&
                    timer == TIMER_W'(SUSP_STOP_CYC - 1)) begin
                    next_state = PW_STOPPED;
                end
            end
            PW_STOPPED: begin
                if (wakeS || resumeS || csActive) next_state = PW_WAKING;
            end
            PW_WAKING: begin
                if (timer == TIMER_W'(WAKE_UP_CYC - 1)) next_state = PW_AWAKE;
            end
            PW_AWAKE: begin
                if (!suspended) begin
                    next_state = PW_RUN;
                end else if (hwWake) begin
                    if (!wakeS && timer == TIMER_W'(WAKE_LOW_CYC)) next_state = PW_STOPPED;
                end else if (!csActive) begin
                    next_state = PW_SUSP_WAIT;
                end
            end
            default: next_state = PW_RUN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= PW_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Remember whether the pin caused the wake
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hwWake <= 1'b0;
        end else if (state == PW_STOPPED && next_state == PW_WAKING) begin
            hwWake <= wakeS;
        end
    end

    // One saturating timer serves every wait; restarts on each state change
    always_ff @(posedge core_clk) begin
        if (reset) begin
            timer <= '0;
        end else if (next_state != state) begin
            timer <= '0;
        end else if ((state == PW_AWAKE && wakeS) || (state == PW_SUSP_WAIT && csActive)) begin
            timer <= '0;
        end else if (timer != TIMER_W'(TMAX)) begin
            timer <= timer + 1'b1;
        end
    end

    // Power controls; oscillator and PLL come up together, before the clock, so the clock is clean
    always_ff @(posedge core_clk) begin
        if (reset) begin
            clockOn <= 1'b1;
            pllOn <= 1'b1;
            xtalOn <= 1'b1;
            regulatorDown <= 1'b0;
        end else begin
            clockOn <= state == PW_RUN || state == PW_SUSP_WAIT || state == PW_AWAKE;
            pllOn <= state != PW_STOPPED;
            xtalOn <= state != PW_STOPPED;
            regulatorDown <= state == PW_STOPPED;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_susp_pin_set: assert property (
        regWr(commit, cmd, IDX_MODE_CTL) && wrFs == FS_SUSP
        |=> suspendPin && suspended ##1 state != PW_RUN)
        else $error("suspend write did not raise indicator");
    chk_susp_pin_hold: assert property (
        suspendPin && !(regWr(commit, cmd, IDX_MODE_CTL) && !wrFs[0]) |=> suspendPin)
        else $error("indicator fell without reset or operational write");
    chk_power_off: assert property (
        state == PW_STOPPED |=> !clockOn && !pllOn && !xtalOn && regulatorDown)
        else $error("power not reduced while stopped");
    chk_stop_time: assert property (
        state == PW_SUSP_WAIT && suspended && !hwSetup[KEEP_CLK_BIT] && !csActive &&
        timer == TIMER_W'(SUSP_STOP_CYC - 1) |=> state == PW_STOPPED ##1 !clockOn)
        else $error("clock not stopped after suspend time");
    chk_keep_clock: assert property (
        state == PW_SUSP_WAIT && hwSetup[KEEP_CLK_BIT] |=> state != PW_STOPPED)
        else $error("clock stopped although kept in suspend");
    chk_clock_up: assert property (
        state == PW_WAKING && hwWake && timer == TIMER_W'(WAKE_UP_CYC - 1)
        |=> clockUp ##1 clockOn)
        else $error("clock-up flag or clock missing after wake time");
    chk_pin_wake: assert property (
        state == PW_STOPPED && wakeS |=> state == PW_WAKING && timer == 0)
        else $error("wake pin did not start wake-up");
    chk_hold_awake: assert property (
        state == PW_AWAKE && wakeS |=> state != PW_STOPPED && timer <= 1)
        else $error("clock stopped while wake pin high");
    chk_cs_wake: assert property (
        state == PW_STOPPED && csActive |=> state == PW_WAKING ##1 pllOn)
        else $error("chip select did not wake");
    chk_resume_evt: assert property (
        resumeS && suspended && !regWr(commit, cmd, IDX_MODE_CTL)
        |=> modeCtl[FS_LSB+1:FS_LSB] == FS_RESUME && resumeSeen)
        else $error("resume not recorded");
    chk_remote_wake: assert property (
        modeCtl[WAKE_EN_BIT] && resumeSeen |=> remoteWake)
        else $error("remote wake not signalled");

    cov_stop: cover property (state == PW_SUSP_WAIT ##1 state == PW_STOPPED);
    cov_pin_wake: cover property (state == PW_WAKING && hwWake ##1 state == PW_AWAKE);
    cov_fall_back: cover property (state == PW_AWAKE ##1 state == PW_STOPPED);
    cov_resume: cover property (state == PW_STOPPED && resumeS);
endmodule

/* verification/hsw_cpu_model.sv */
`timescale 1ns/10ps
module hsw_cpu_model import hsw_pkg::*; (
    input wire logic core_clk,
    input wire logic [15:0] busDataOut,
    input wire logic busDataOeN,
    output hsw_pkg::hsw_bus_in_t busIn
);
    logic lastOe;

    // Strobes idle high from time zero
    initial begin
        busIn = {1'b1, 1'b1, 1'b1, 1'b0, 16'h0000};
        lastOe = 1'b1;
    end

    // One strobe held six edges, so the two-flop sampling can never miss it
    task automatic xfer(input logic isCmd, input logic isRd, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge core_clk);
        busIn.csN <= 1'b0;
        busIn.a0 <= isCmd;
        busIn.rdN <= ~isRd;
        busIn.wrN <= isRd;
        busIn.data <= isRd ? ~busIn.data : d;
        repeat (6) @(posedge core_clk);
        q = busDataOut;
        lastOe = busDataOeN;
        busIn.csN <= 1'b1;
        busIn.rdN <= 1'b1;
        busIn.wrN <= 1'b1;
        busIn.data <= ~busIn.data; // Released lines never keep the last value
        repeat (3) @(posedge core_clk);
    endtask

    // Command then one data word for the 16-bit registers
    task automatic wr16(input logic [6:0] idx, input logic [15:0] d);
        logic [15:0] q;
        xfer(1'b1, 1'b0, {8'h00, 1'b1, idx}, q);
        xfer(1'b0, 1'b0, d, q);
    endtask

    task automatic rd16(input logic [6:0] idx, output logic [15:0] q);
        xfer(1'b1, 1'b0, {8'h00, 1'b0, idx}, q);
        xfer(1'b0, 1'b1, 16'h0000, q);
    endtask

    // Wide registers go low half first, committed on the high half
    task automatic wr32(input logic [6:0] idx, input logic [31:0] d);
        logic [15:0] q;
        xfer(1'b1, 1'b0, {8'h00, 1'b1, idx}, q);
        xfer(1'b0, 1'b0, d[15:0], q);
        xfer(1'b0, 1'b0, d[31:16], q);
    endtask

    task automatic rd32(input logic [6:0] idx, output logic [31:0] q);
        logic [15:0] lo;
        logic [15:0] hi;
        xfer(1'b1, 1'b0, {8'h00, 1'b0, idx}, lo);
        xfer(1'b0, 1'b1, 16'h0000, lo);
        xfer(1'b0, 1'b1, 16'h0000, hi);
        q = {hi, lo};
    endtask

    // Reserved bits keep whatever the register held before
    task automatic rmw32(input logic [6:0] idx, input logic [31:0] mask, input logic [31:0] val);
        logic [31:0] cur;
        rd32(idx, cur);
        wr32(idx, (cur & ~mask) | (val & mask));
    endtask
endmodule

/* verification/host_suspend_wakeup_control_tb.sv */
`timescale 1ns/10ps
module host_suspend_wakeup_control_tb;
    import hsw_pkg::*;
    localparam int STOP_CYC = 40;
    localparam int WAKE_CYC = 10;
    localparam int LOW_CYC = 20;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic wakeRequestPin = 1'b0;
    logic resumeSignal = 1'b0;
    hsw_bus_in_t busIn;
    logic [15:0] busDataOut;
    logic busDataOeN, suspendPin, clockOn, pllOn, xtalOn, regulatorDown, remoteWake;
    int err_count = 0;
    int checks = 0;
    logic [15:0] q;
    logic [31:0] w;
    int n;
    int bad;

    // Short counts keep the suspend timers within a quick run
    hsw_wake_ctrl #(.SUSP_STOP_CYC(STOP_CYC), .WAKE_UP_CYC(WAKE_CYC), .WAKE_LOW_CYC(LOW_CYC)) u_dut (
        .core_clk(core_clk), .reset(reset), .busIn(busIn), .wakeRequestPin(wakeRequestPin),
        .resumeSignal(resumeSignal), .busDataOut(busDataOut), .busDataOeN(busDataOeN),
        .suspendPin(suspendPin), .clockOn(clockOn), .pllOn(pllOn), .xtalOn(xtalOn),
        .regulatorDown(regulatorDown), .remoteWake(remoteWake));
    hsw_cpu_model u_cpu (.core_clk(core_clk), .busDataOut(busDataOut),
        .busDataOeN(busDataOeN), .busIn(busIn));

    always #2.5 core_clk = ~core_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Counts settled cycles until the clock gate reaches the wanted level
    task automatic wait_clock(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        #1;
        while (clockOn !== lvl && cnt < lim) begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
    endtask

    task automatic set_field(input logic [1:0] fs);
        u_cpu.rmw32(IDX_MODE_CTL, 32'h0000_00c0, {24'h0, fs, 6'h00});
    endtask

    task automatic t_reset;
        chk({suspendPin, clockOn, pllOn, xtalOn, regulatorDown, remoteWake}, 6'b011100, "idle pins");
        u_cpu.rd32(IDX_MODE_CTL, w);
        chk(w, MODE_CTL_RESET, "mode reset");
        chk({31'h0, u_cpu.lastOe}, 32'h0, "read enable");
        u_cpu.rd32(IDX_HOST_EN, w);
        chk(w, HOST_EN_RESET, "host enable reset");
        u_cpu.rd16(IDX_HW_SETUP, q);
        chk(q, HW_SETUP_RESET, "setup reset");
        u_cpu.rd32(7'h02, w);
        chk(w, 32'h0, "unmapped read");
    endtask

    task automatic t_keep_clock;
        u_cpu.wr16(IDX_HW_SETUP, 16'h0800);
        set_field(FS_SUSP);
        chk(suspendPin, 1'b1, "indicator on");
        repeat (STOP_CYC + 20) @(posedge core_clk);
        #1;
        chk(clockOn, 1'b1, "clock kept");
        u_cpu.rd16(IDX_HW_SETUP, q);
        chk(q, 16'h0800, "setup readback");
        set_field(FS_OPER);
        chk(suspendPin, 1'b0, "indicator cleared by operational");
        u_cpu.wr16(IDX_HW_SETUP, 16'h0000);
    endtask

    task automatic t_stop;
        u_cpu.wr16(IDX_PROC_EN, 16'h0040);
        set_field(FS_SUSP);
        wait_clock(1'b0, STOP_CYC + 40, n);
        chk(32'(n >= STOP_CYC - 12 && n <= STOP_CYC + 12), 32'h1, "stop delay");
        @(posedge core_clk);
        #1;
        chk({pllOn, xtalOn, regulatorDown}, 3'b001, "power down");
    endtask

    task automatic t_pin_wake;
        @(posedge core_clk);
        wakeRequestPin <= 1'b1;
        wait_clock(1'b1, WAKE_CYC + 30, n);
        chk(32'(n >= WAKE_CYC && n <= WAKE_CYC + 8), 32'h1, "wake delay");
        bad = 0;
        repeat (50) begin
            @(posedge core_clk);
            #1;
            bad += (clockOn !== 1'b1);
        end
        chk(bad, 0, "clock held");
        u_cpu.rd16(IDX_PROC_FLAGS, q);
        chk(q, 16'h0040, "clock-up flag");
        u_cpu.wr16(IDX_PROC_FLAGS, 16'h0040);
        u_cpu.rd16(IDX_PROC_FLAGS, q);
        chk(q, 16'h0000, "flag cleared");
        @(posedge core_clk);
        wakeRequestPin <= 1'b0;
        wait_clock(1'b0, LOW_CYC + 40, n);
        chk(32'(n >= LOW_CYC && n <= LOW_CYC + 10), 32'h1, "fall back");
        chk(suspendPin, 1'b1, "indicator held");
    endtask

    task automatic t_cs_wake;
        u_cpu.wr16(IDX_HW_SETUP, 16'h0000);
        wait_clock(1'b1, WAKE_CYC + 20, n);
        chk(clockOn, 1'b1, "select wake");
    endtask

    task automatic t_resume;
        u_cpu.rmw32(IDX_MODE_CTL, 32'h0000_0400, 32'h0000_0400);
        @(posedge core_clk);
        resumeSignal <= 1'b1;
        repeat (8) @(posedge core_clk);
        resumeSignal <= 1'b0;
        u_cpu.rd32(IDX_MODE_CTL, w);
        chk(w, 32'h0000_0440, "resume state");
        u_cpu.rd32(IDX_HOST_FLAGS, w);
        chk(w, 32'h0000_0040, "resume flag");
        chk({remoteWake, suspendPin}, 2'b11, "remote wake");
        u_cpu.wr32(IDX_HOST_FLAGS, 32'h0000_0040);
        repeat (2) @(posedge core_clk);
        chk(remoteWake, 1'b0, "remote wake off");
        set_field(FS_RESET);
        chk(suspendPin, 1'b0, "indicator cleared by reset");
    endtask

    // Main sequence after a twelve-cycle reset
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_keep_clock();
        t_stop();
        t_pin_wake();
        t_cs_wake();
        t_stop();
        t_resume();
        tally_and_finish();
    end

    // Watchdog well beyond the thousand or so cycles the sequence needs
    initial begin
        repeat (30000) @(posedge core_clk);
        err_count++;
        tally_and_finish();
    end
endmodule
